// ===== include/drive_seq_pkg.sv
package drive_seq_pkg;

  // object indices seen on the link
  localparam logic [15:0] OBJ_COMMAND       = 16'h6040;
  localparam logic [15:0] OBJ_STATE         = 16'h6041;
  localparam logic [15:0] OBJ_MODE          = 16'h6060;
  localparam logic [15:0] OBJ_HOMING_METHOD = 16'h6098;

  // mode selector codes
  localparam logic [15:0] MODE_HOMING = 16'h0006;
  localparam logic [15:0] MODE_INTERP = 16'h0007;

  // command words of the power-up sequence
  localparam logic [15:0] CW_DISABLE   = 16'h0000;
  localparam logic [15:0] CW_SHUTDOWN  = 16'h0006;
  localparam logic [15:0] CW_SWITCH_ON = 16'h0007;
  localparam logic [3:0]  CW_ENABLE_NIB = 4'hf;
  localparam int          CW_RUN_BIT   = 4;
  localparam int          CW_HALT_BIT  = 8;

  // state word base patterns and mode bits
  localparam logic [15:0] SW_DISABLED    = 16'h0050;
  localparam logic [15:0] SW_READY       = 16'h0031;
  localparam logic [15:0] SW_SWITCHED_ON = 16'h0033;
  localparam logic [15:0] SW_ENABLED     = 16'h0037;
  localparam logic [15:0] SW_STATE_MASK  = 16'h006f;
  localparam int          SW_TARGET_BIT  = 10;
  localparam int          SW_ACTIVE_BIT  = 12;
  localparam int          SW_ERROR_BIT   = 13;

  // values after reset
  localparam logic [15:0] CMD_RESET    = 16'h0000;
  localparam logic [15:0] MODE_RESET   = 16'h0000;
  localparam logic [15:0] METHOD_RESET = 16'h0000;

  // controller register offsets on wishbone (byte addresses)
  localparam logic [3:0] WB_CMD_OFS    = 4'h0;
  localparam logic [3:0] WB_MODE_OFS   = 4'h4;
  localparam logic [3:0] WB_METHOD_OFS = 4'h8;
  localparam logic [3:0] WB_STATUS_OFS = 4'hc;
  localparam int         WB_BUSY_BIT    = 16;
  localparam int         WB_REFUSED_BIT = 17;

  // power-up sequence states, one-hot
  typedef enum logic [3:0] {
    ST_DISABLED    = 4'b0001,
    ST_READY       = 4'b0010,
    ST_SWITCHED_ON = 4'b0100,
    ST_ENABLED     = 4'b1000
  } drive_state_t;

endpackage : drive_seq_pkg

// ===== include/drive_link_if.sv
// object write link between the controller and the drive sequencer
interface drive_link_if;
  logic        objWe;     // object write request, held until objAck
  logic [15:0] objIndex;  // object index
  logic [15:0] objData;   // object value
  logic        objAck;    // one-cycle answer to objWe
  logic [15:0] stateWord; // drive state word, always valid

  modport device (
    input  objWe,
    input  objIndex,
    input  objData,
    output objAck,
    output stateWord
  );

  modport master (
    output objWe,
    output objIndex,
    output objData,
    input  objAck,
    input  stateWord
  );
endinterface : drive_link_if

// ===== verilog/drive_mode_sequencer.sv
// How it works
// - 0x0006 gives 0x0031, 0x0007 gives 0x0033, 0x000F enables
// - homing start uses same sequence from 0x0000
// - enabled only after three ordered steps
// - motion states change only when enabled
// - 0x001F in interpolated mode starts, bit12 set
// - enabled to 0x0007 stops interpolation
// - 0x001F restarts interpolation after stop
// - mode selection accepted at 0x0007
// - master refuses mode writes while the state word shows 0xnn37
// - mode value 6 selects homing
// - homing method taken from object 0x6098
// - bit4 edges start and interrupt homing
// - halt bit stops axle, stays enabled
// - bit10 shows home reached or standstill
// - bit12 set when homing succeeds
// - bit13 set when homing fails
// - 0x001F starts homing, attained shows 0x1n37
// - mode value 7 selects interpolation
// - bit12 shows interpolation active
//
// Implementation choice: register access over Wishbone.
module drive_mode_sequencer
  import drive_seq_pkg::*;
(
  input  wire logic           ref_clk,
  input  wire logic           rst_b,
  drive_link_if.device        link,
  input  wire logic           homeReached,
  input  wire logic           homeFailed,
  input  wire logic           axleStopped,
  input  wire logic           positionInWindow,
  output logic                interpRunningFlag,
  output logic                homingRun,
  output logic                haltStop,
  output logic                driveEnabled,
  output logic [15:0]         homingMethod,
  output logic [15:0]         opMode
);

  // low nibble F marks an enabling command word
  function automatic logic isEnableWord(input logic [15:0] w);
    isEnableWord = (w[3:0] == CW_ENABLE_NIB);
  endfunction : isEnableWord

  // base state word for each sequence state
  function automatic logic [15:0] stateBase(input drive_state_t s);
    unique case (s)
      ST_READY:       stateBase = SW_READY;
      ST_SWITCHED_ON: stateBase = SW_SWITCHED_ON;
      ST_ENABLED:     stateBase = SW_ENABLED;
      default:        stateBase = SW_DISABLED;
    endcase
  endfunction : stateBase

  drive_state_t state_r;          // power-up sequence state
  drive_state_t state_nxt;        // its next value
  logic [15:0]  cmd_r;            // last accepted command word
  logic [15:0]  mode_r;           // selected mode of operation
  logic [15:0]  method_r;         // homing method object
  logic         ipRun_r;          // interpolation active
  logic         ipRun_nxt;
  logic         homeActive_r;     // homing in progress
  logic         homeActive_nxt;
  logic         homeAttained_r;   // homing finished well
  logic         homeAttained_nxt;
  logic         homeError_r;      // homing failed
  logic         homeError_nxt;
  logic         ack_r;            // link answer pulse
  logic [15:0]  stateWord_r;      // registered state word

  // link decode
  wire         objTake    = link.objWe & ~ack_r;
  wire         cmdTake    = objTake & (link.objIndex == OBJ_COMMAND);
  wire         isEnabled  = (state_r == ST_ENABLED);
  // mode changes are refused while enabled, accepted in other states
  wire         modeTake   = objTake & (link.objIndex == OBJ_MODE) & ~isEnabled;
  wire         methodTake = objTake & (link.objIndex == OBJ_HOMING_METHOD);
  wire [15:0]  newCmd     = link.objData;

  // edges of the run bit, evaluated only when a new word lands
  wire runRise = cmdTake & newCmd[CW_RUN_BIT] & ~cmd_r[CW_RUN_BIT];
  wire runFall = cmdTake & ~newCmd[CW_RUN_BIT] & cmd_r[CW_RUN_BIT];

  // mode decode of the current selection
  wire modeHoming = (mode_r == MODE_HOMING);
  wire modeInterp = (mode_r == MODE_INTERP);
  wire willEnable = (state_nxt == ST_ENABLED);
  wire haltNow    = cmd_r[CW_HALT_BIT];

  // sequence state next value
  always_comb begin
    // out-of-order words leave the state alone
    state_nxt = state_r;
    if (cmdTake) begin
      if (newCmd == CW_DISABLE) begin
        state_nxt = ST_DISABLED;
      end else begin
        unique case (state_r)
          ST_DISABLED: begin
            if (newCmd == CW_SHUTDOWN) begin
              state_nxt = ST_READY;
            end
          end
          ST_READY: begin
            if (newCmd == CW_SWITCH_ON) begin
              state_nxt = ST_SWITCHED_ON;
            end
          end
          ST_SWITCHED_ON: begin
            if (isEnableWord(newCmd)) begin
              state_nxt = ST_ENABLED;
            end else if (newCmd == CW_SHUTDOWN) begin
              state_nxt = ST_READY;
            end
          end
          ST_ENABLED: begin
            // back to switched on stops motion
            if (newCmd == CW_SWITCH_ON) begin
              state_nxt = ST_SWITCHED_ON;
            end else if (newCmd == CW_SHUTDOWN) begin
              state_nxt = ST_READY;
            end
          end
          // an illegal state code falls back to disabled
          default: begin
            state_nxt = ST_DISABLED;
          end
        endcase
      end
    end
  end

  // interpolation run flag
  always_comb begin
    ipRun_nxt = ipRun_r;
    if (!willEnable || !modeInterp) begin
      ipRun_nxt = 1'b0;
    // rising run bit starts, also after a stop
    end else if (runRise) begin
      ipRun_nxt = 1'b1;
    end else if (runFall) begin
      ipRun_nxt = 1'b0;
    end
  end

  // homing progress and result flags
  always_comb begin
    homeActive_nxt   = homeActive_r;
    homeAttained_nxt = homeAttained_r;
    homeError_nxt    = homeError_r;
    if (!willEnable || !modeHoming) begin
      homeActive_nxt = 1'b0;
    end else if (runRise) begin
      homeActive_nxt   = 1'b1;
      homeAttained_nxt = 1'b0;
      homeError_nxt    = 1'b0;
    end else if (runFall) begin
      homeActive_nxt = 1'b0;
    // halt freezes progress; reached and failed inputs obeyed only without halt
    end else if (homeActive_r && !haltNow) begin
      if (homeFailed) begin
        homeActive_nxt = 1'b0;
        homeError_nxt  = 1'b1;
      end else if (homeReached) begin
        homeActive_nxt   = 1'b0;
        homeAttained_nxt = 1'b1;
      end
    end
  end

  // target bit: standstill under halt, else goal reached
  wire targetHome   = haltNow ? axleStopped : homeAttained_r;
  wire targetInterp = haltNow ? axleStopped : positionInWindow;

  // mode-specific bits of the state word
  logic [15:0] modeBits;
  always_comb begin
    modeBits = 16'h0000;
    if (modeHoming) begin
      modeBits[SW_TARGET_BIT] = targetHome;
      modeBits[SW_ACTIVE_BIT] = homeAttained_r;
      modeBits[SW_ERROR_BIT]  = homeError_r;
    end else if (modeInterp && isEnabled) begin
      modeBits[SW_TARGET_BIT] = targetInterp;
      modeBits[SW_ACTIVE_BIT] = ipRun_r;
    end
  end

  // sequence and command registers
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state_r <= ST_DISABLED;
      cmd_r   <= CMD_RESET;
    end else begin
      state_r <= state_nxt;
      if (cmdTake) begin
        cmd_r <= newCmd;
      end
    end
  end

  // object registers: mode and homing method
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      mode_r   <= MODE_RESET;
      method_r <= METHOD_RESET;
    end else begin
      if (modeTake) begin
        mode_r <= link.objData;
      end
      if (methodTake) begin
        method_r <= link.objData;
      end
    end
  end

  // motion flags
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ipRun_r        <= 1'b0;
      homeActive_r   <= 1'b0;
      homeAttained_r <= 1'b0;
      homeError_r    <= 1'b0;
    end else begin
      ipRun_r        <= ipRun_nxt;
      homeActive_r   <= homeActive_nxt;
      homeAttained_r <= homeAttained_nxt;
      homeError_r    <= homeError_nxt;
    end
  end

  // link answer and state word; word lags the state by one cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ack_r       <= 1'b0;
      stateWord_r <= SW_DISABLED;
    end else begin
      ack_r       <= objTake;
      stateWord_r <= stateBase(state_r) | modeBits;
    end
  end

  assign link.objAck    = ack_r;
  assign link.stateWord = stateWord_r;

  // user-side outputs
  assign interpRunningFlag = ipRun_r;
  assign homingRun         = homeActive_r & ~haltNow;
  assign haltStop          = isEnabled & haltNow;
  assign driveEnabled      = isEnabled;
  assign homingMethod      = method_r;
  assign opMode            = mode_r;

endmodule : drive_mode_sequencer

// ===== verilog/plc_link_master.sv
// controller end: software writes objects over wishbone, this end
// forwards them on the link and shows the drive state word
module plc_link_master
  import drive_seq_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_b,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [31:0]       wb_dat_i,
  input  wire logic              wb_we_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  output logic [31:0]            wb_dat_o,
  output logic                   wb_ack_o,
  drive_link_if.master           link
);

  // merge the two low byte lanes of a write over an old value
  function automatic logic [15:0] mergeLanes(input logic [15:0] old,
                                             input logic [31:0] d,
                                             input logic [3:0]  s);
    mergeLanes = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : mergeLanes

  logic        ack_r;      // wishbone answer
  logic [31:0] dat_r;      // read data
  logic        objWe_r;    // link request outstanding
  logic [15:0] idx_r;      // link object index
  logic [15:0] data_r;     // link object value
  logic [15:0] cmdShadow_r;
  logic [15:0] modeShadow_r;
  logic [15:0] methShadow_r;
  logic        refused_r;  // a mode write was blocked since the last launch

  // bus decode
  wire       wbReq   = wb_cyc_i & wb_stb_i & ~ack_r;
  wire [3:0] ofs     = wb_adr_i[3:0];
  wire       mapped  = (wb_adr_i[ADDR_W-1:4] == '0);
  wire       hitCmd  = mapped & (ofs == WB_CMD_OFS);
  wire       hitMode = mapped & (ofs == WB_MODE_OFS);
  wire       hitMeth = mapped & (ofs == WB_METHOD_OFS);
  wire       hitStat = mapped & (ofs == WB_STATUS_OFS);
  // no mode change while the drive shows enabled
  // both sides masked: the enabled pattern carries bit 4, which the mask drops
  wire       driveOn = (link.stateWord & SW_STATE_MASK) == (SW_ENABLED & SW_STATE_MASK);
  wire       modeBlk = hitMode & driveOn;
  wire       linkWr  = wbReq & wb_we_i & (hitCmd | hitMeth | (hitMode & ~driveOn));
  wire       launch  = linkWr & ~objWe_r;
  wire       linkDone = objWe_r & link.objAck;

  // value and index of the write to forward
  wire [15:0] oldVal  = hitCmd ? cmdShadow_r : (hitMode ? modeShadow_r : methShadow_r);
  wire [15:0] newVal  = mergeLanes(oldVal, wb_dat_i, wb_sel_i);
  wire [15:0] newIdx  = hitCmd ? OBJ_COMMAND : (hitMode ? OBJ_MODE : OBJ_HOMING_METHOD);

  // read mux
  wire [31:0] rdVal =
    hitCmd  ? {16'h0000, cmdShadow_r} :
    hitMode ? {16'h0000, modeShadow_r} :
    hitMeth ? {16'h0000, methShadow_r} :
    hitStat ? {14'h0000, refused_r, objWe_r, link.stateWord} : 32'h0000_0000;

  // link request: held until the drive answers
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      objWe_r <= 1'b0;
      idx_r   <= OBJ_COMMAND;
      data_r  <= CMD_RESET;
    end else if (launch) begin
      // sequence words go out in software order
      objWe_r <= 1'b1;
      idx_r   <= newIdx;
      data_r  <= newVal;
    end else if (linkDone) begin
      objWe_r <= 1'b0;
    end
  end

  // shadows follow only what the drive acknowledged
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      cmdShadow_r  <= CMD_RESET;
      modeShadow_r <= MODE_RESET;
      methShadow_r <= METHOD_RESET;
    end else if (linkDone) begin
      if (idx_r == OBJ_COMMAND) begin
        cmdShadow_r <= data_r;
      end
      if (idx_r == OBJ_MODE) begin
        modeShadow_r <= data_r;
      end
      if (idx_r == OBJ_HOMING_METHOD) begin
        methShadow_r <= data_r;
      end
    end
  end

  // refused flag: set on a blocked mode write, cleared by a launch
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      refused_r <= 1'b0;
    end else if (wbReq && wb_we_i && modeBlk) begin
      refused_r <= 1'b1;
    end else if (launch) begin
      refused_r <= 1'b0;
    end
  end

  // wishbone answer: link writes wait for the drive, all else next cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= (wbReq & ~linkWr) | linkDone;
      if (wbReq && !wb_we_i) begin
        dat_r <= rdVal;
      end
    end
  end

  assign wb_ack_o      = ack_r;
  assign wb_dat_o      = dat_r;
  assign link.objWe    = objWe_r;
  assign link.objIndex = idx_r;
  assign link.objData  = data_r;

endmodule : plc_link_master

// ===== tb/drive_link_checker.sv
// watches the object link between the controller end and the drive end
module drive_link_checker
  import drive_seq_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_b,
  input wire logic        objWe,
  input wire logic [15:0] objIndex,
  input wire logic [15:0] objData,
  input wire logic        objAck,
  input wire logic [15:0] stateWord
);
  timeunit 1ns;
  timeprecision 1ps;

  logic interpSel_r;   // interpolation selected, as seen on the link
  logic interpSel_nxt; // next value of the tracker
  wire  modeTaken = objWe && !objAck && objIndex == OBJ_MODE;
  // a mode write while enabled is refused by the drive, so ignore it here
  assign interpSel_nxt = (modeTaken && stateWord[7:0] != 8'h37) ?
                         (objData == MODE_INTERP) : interpSel_r;

  // tracker register
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      interpSel_r <= 1'b0;
    end else begin
      interpSel_r <= interpSel_nxt;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  // a request is taken when write is high and no answer stands
  sequence s_taken;
    objWe && !objAck;
  endsequence
  // a command word taken while the state pattern is st
  sequence s_cmd(logic [15:0] v, logic [7:0] st);
    s_taken ##0 (objIndex == OBJ_COMMAND && objData == v && stateWord[7:0] == st);
  endsequence

  // state word is settled three edges after the taking edge, whatever the split
  property p_ack_answer;   s_taken |=> objAck; endproperty
  property p_ack_pulse;    objAck |=> !objAck; endproperty
  property p_ack_idle;     !objWe |=> !objAck; endproperty
  property p_we_drop;      objAck |=> !objWe; endproperty
  property p_req_hold;     s_taken |=> objWe && $stable(objIndex) && $stable(objData); endproperty
  property p_shutdown;     s_cmd(CW_SHUTDOWN, 8'h50) |-> ##3 stateWord[7:0] == 8'h31; endproperty
  property p_switch_on;    s_cmd(CW_SWITCH_ON, 8'h31) |-> ##3 stateWord[7:0] == 8'h33; endproperty
  property p_enable;       s_cmd(16'h000f, 8'h33) |-> ##3 stateWord[7:0] == 8'h37; endproperty
  property p_no_skip;
    s_taken ##0 (objIndex == OBJ_COMMAND && stateWord[7:0] == 8'h50 && objData[3:0] == 4'hf)
      |-> ##3 stateWord[7:0] == 8'h50;
  endproperty
  property p_interp_start;
    interpSel_r ##0 s_cmd(16'h001f, 8'h37) |-> ##3 stateWord[12] && stateWord[7:0] == 8'h37;
  endproperty
  property p_interp_stop;
    interpSel_r ##0 s_cmd(CW_SWITCH_ON, 8'h37) |-> ##3 !stateWord[12] && stateWord[7:0] == 8'h33;
  endproperty
  property p_halt_keep;    s_cmd(16'h011f, 8'h37) |-> ##3 stateWord[7:0] == 8'h37; endproperty

  a_ack_answer:   assert property (p_ack_answer) else $error("no link answer");
  a_ack_pulse:    assert property (p_ack_pulse) else $error("link answer too long");
  a_ack_idle:     assert property (p_ack_idle) else $error("answer without request");
  a_we_drop:      assert property (p_we_drop) else $error("request not dropped");
  a_req_hold:     assert property (p_req_hold) else $error("request changed early");
  a_shutdown:     assert property (p_shutdown) else $error("shutdown not ready");
  a_switch_on:    assert property (p_switch_on) else $error("switch on failed");
  a_enable:       assert property (p_enable) else $error("enable failed");
  a_no_skip:      assert property (p_no_skip) else $error("sequence skipped");
  a_interp_start: assert property (p_interp_start) else $error("interp not run");
  a_interp_stop:  assert property (p_interp_stop) else $error("interp not stop");
  a_halt_keep:    assert property (p_halt_keep) else $error("halt left enabled");
endmodule : drive_link_checker

// ===== tb/test_drive_mode_sequencer.sv
// controller end and drive end joined on the link, driven from wishbone
module test_drive_mode_sequencer;
  import drive_seq_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        refClk;            // bench clock, 200 MHz
  logic        rstB;              // synchronous reset, active low
  logic [7:0]  wbAdr;             // wishbone byte address
  logic [31:0] wbWdat;            // wishbone write data
  logic [31:0] wbRdat;            // wishbone read data
  logic        wbWe;              // write strobe
  logic [3:0]  wbSel;             // byte lanes, all enabled except one low-lane write
  logic        wbCyc;             // cycle
  logic        wbStb;             // strobe
  logic        wbAck;             // answer from the controller end
  logic        homeReached;       // homing found home
  logic        homeFailed;        // homing error
  logic        axleStopped;       // axle at zero velocity
  logic        positionInWindow;  // interpolated target reached
  logic        interpRunningFlag; // interpolation active
  logic        homingRun;         // homing moving
  logic        haltStop;          // halt holding the axle
  logic        driveEnabled;      // operation enabled
  logic [15:0] homingMethod;      // method object
  logic [15:0] opMode;            // mode selector
  int          errCount;          // mismatches
  int          testsRun;          // comparisons

  drive_link_if link();

  drive_mode_sequencer drive_mode_sequencer_i (
    .ref_clk(refClk), .rst_b(rstB), .link(link), .homeReached(homeReached),
    .homeFailed(homeFailed), .axleStopped(axleStopped), .positionInWindow(positionInWindow),
    .interpRunningFlag(interpRunningFlag), .homingRun(homingRun), .haltStop(haltStop),
    .driveEnabled(driveEnabled), .homingMethod(homingMethod), .opMode(opMode));

  plc_link_master #(.ADDR_W(8)) plc_link_master_i (
    .ref_clk(refClk), .rst_b(rstB), .wb_adr_i(wbAdr), .wb_dat_i(wbWdat), .wb_we_i(wbWe),
    .wb_sel_i(wbSel), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_dat_o(wbRdat),
    .wb_ack_o(wbAck), .link(link));

  drive_link_checker drive_link_checker_i (
    .ref_clk(refClk), .rst_b(rstB), .objWe(link.objWe), .objIndex(link.objIndex),
    .objData(link.objData), .objAck(link.objAck), .stateWord(link.stateWord));

  // free-running clock
  initial begin
    refClk = 1'b0;
    forever begin
      #2.5 refClk = ~refClk;
    end
  end

  // compare and count; x never matches
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      errCount++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one classic cycle, held until ack is sampled high at a rising edge
  task automatic wbXfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                        output logic [31:0] q);
    wbAdr  <= a;
    wbWe   <= w;
    wbWdat <= d;
    wbCyc  <= 1'b1;
    wbStb  <= 1'b1;
    @(posedge refClk);
    // no cycle count assumed; only the watchdog ends a hung wait
    while (wbAck !== 1'b1) begin
      @(posedge refClk);
    end
    q = wbRdat;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe  <= 1'b0;
    @(posedge refClk);
  endtask : wbXfer

  // register write
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] q;
    wbXfer(a, 1'b1, {16'h0000, d}, q);
  endtask : wr

  // register read with expected value
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wbXfer(a, 1'b0, 32'h0, q);
    chk(q, exp);
  endtask : rd

  // command word, then the state word it must leave
  task automatic cmd(input logic [15:0] cw, input logic [15:0] exp);
    wr(8'h00, cw);
    rd(8'h0c, {16'h0000, exp});
  endtask : cmd

  // one-cycle pulse on a homing input, then let the state word settle
  task automatic pulse(input logic failed);
    if (failed) homeFailed <= 1'b1;
    else homeReached <= 1'b1;
    @(posedge refClk);
    homeFailed  <= 1'b0;
    homeReached <= 1'b0;
    repeat (3) @(posedge refClk);
  endtask : pulse

  // verdict, the single end of the run
  task automatic wrapUp;
    $display("checks %0d mismatches %0d", testsRun, errCount);
    if (errCount == 0 && testsRun > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrapUp

  // the whole sequence takes well under a thousand cycles
  initial begin
    repeat (20000) @(posedge refClk);
    errCount++;
    $display("MISMATCH at %0t: run timed out", $time);
    wrapUp();
  end

  initial begin
    errCount = 0;
    testsRun = 0;
    rstB = 1'b0;
    {wbAdr, wbWdat, wbWe, wbCyc, wbStb} = '0;
    wbSel = 4'hf;
    {homeReached, homeFailed, axleStopped, positionInWindow} = 4'h0;
    repeat (20) @(posedge refClk);
    rstB <= 1'b1;
    @(posedge refClk);
    rd(8'h0c, 32'h0000_0050);
    rd(8'h04, 32'h0);
    rd(8'h08, 32'h0);
    rd(8'h10, 32'h0);
    chk({31'h0, driveEnabled}, 32'h0);
    // interpolated mode start, out-of-order words first
    cmd(CW_DISABLE, SW_DISABLED);
    wr(8'h04, MODE_INTERP);
    cmd(16'h000f, SW_DISABLED);
    cmd(CW_SHUTDOWN, SW_READY);
    cmd(16'h000f, SW_READY);
    cmd(CW_SWITCH_ON, SW_SWITCHED_ON);
    cmd(16'h000f, SW_ENABLED);
    chk({31'h0, driveEnabled}, 32'h1);
    cmd(16'h001f, 16'h1037);
    chk({31'h0, interpRunningFlag}, 32'h1);
    positionInWindow <= 1'b1;
    cmd(CW_SWITCH_ON, 16'h0033);
    chk({31'h0, interpRunningFlag}, 32'h0);
    cmd(16'h001f, 16'h1437);
    cmd(16'h011f, 16'h1037);
    chk({31'h0, haltStop}, 32'h1);
    wr(8'h04, MODE_HOMING);
    rd(8'h0c, 32'h0002_1037);
    chk({16'h0, opMode}, 32'h7);
    // homing selected from switched on
    cmd(CW_SWITCH_ON, 16'h0033);
    wr(8'h04, MODE_HOMING);
    chk({16'h0, opMode}, 32'h6);
    wr(8'h08, 16'h0023);
    chk({16'h0, homingMethod}, 32'h23);
    rd(8'h08, 32'h23);
    // low lane only: the upper byte keeps its earlier value
    wbSel <= 4'h1;
    wr(8'h08, 16'hff45);
    chk({16'h0, homingMethod}, 32'h45);
    wbSel <= 4'hf;
    cmd(16'h000f, 16'h0037);
    chk({31'h0, homingRun}, 32'h0);
    cmd(16'h001f, 16'h0037);
    chk({31'h0, homingRun}, 32'h1);
    pulse(1'b0);
    rd(8'h0c, 32'h0000_1437);
    cmd(16'h000f, 16'h1437);
    chk({31'h0, homingRun}, 32'h0);
    cmd(16'h011f, 16'h0037);
    chk({31'h0, haltStop}, 32'h1);
    axleStopped <= 1'b1;
    // one edge so the state word takes in the new input before the read
    @(posedge refClk);
    rd(8'h0c, 32'h0000_0437);
    axleStopped <= 1'b0;
    cmd(16'h001f, 16'h0037);
    chk({31'h0, homingRun}, 32'h1);
    pulse(1'b1);
    rd(8'h0c, 32'h0000_2037);
    cmd(CW_SWITCH_ON, 16'h2033);
    cmd(CW_DISABLE, 16'h2050);
    wrapUp();
  end
endmodule : test_drive_mode_sequencer
